// ===== rtl/sync_serial_defines.vh
/*
 * register offsets, field positions, reset values and counts of the
 * synchronous serial port. assumes a 32-bit apb slave, word aligned.
 */
`ifndef SYNC_SERIAL_DEFINES_VH
`define SYNC_SERIAL_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_SERIAL_CTRL   12'h000
`define OFS_TX_FIFO_PORT  12'h004
`define OFS_RX_FIFO_PORT  12'h008
`define OFS_SERIAL_FLAGS  12'h00c
`define OFS_FIFO_CTRL     12'h010
`define OFS_FIFO_COUNT    12'h014
`define OFS_PORT_PIN      12'h018
`define OFS_LINE_STATUS   12'h01c

// ----------------------------------------------------------------------
// serial_ctrl_reg fields
// ----------------------------------------------------------------------
`define CTRL_TX_IRQ_EN    7
`define CTRL_RX_IRQ_EN    6
`define CTRL_TX_ON        5
`define CTRL_RX_ON        4
`define CTRL_FAULT_IRQ_EN 3
`define CTRL_CLK_EXT      1

// ----------------------------------------------------------------------
// serial_flags_reg fields
// ----------------------------------------------------------------------
`define FLG_FAULT_SUM     7
`define FLG_TX_DONE       6
`define FLG_TX_LOW        5
`define FLG_LINE_BREAK    4
`define FLG_FRAMING       3
`define FLG_PARITY        2
`define FLG_RX_THRESH     1
`define FLG_DATA_WAIT     0

// ----------------------------------------------------------------------
// other fields, reset values, counts
// ----------------------------------------------------------------------
`define PIN_DIR           1
`define PIN_LEVEL         0
`define FLAGS_RESET       8'h60
`define FIFO_DEPTH        5'h10
`define BITS_PER_CHAR     4'h8
`define SCK_HALF_DIV      8'h04

`endif

// ===== rtl/sync_serial_port.v
/*
 * synchronous-mode serial port with 16-byte tx and rx fifos, four
 * interrupt request lines and a tx pin steered by the port register.
 * assumes an apb master on pclk and a serial partner on txd, rxd, sck.
 */
// The register addresses and the APB slave port are this design's own decisions.
// Operation
// - written byte moves to shifter, shifts out
// - tx low flag when count below threshold
// - tx irq when enable and low flag
// - internal clock gives eight pulses per char
// - lsb first; external clock followed
// - bit 7 checks fifo, reloads back to back
// - empty at bit 7 sets done, holds line
// - clock pin high after transmission
// - receive lsb first synced to clock
// - store if room else overrun, block rx
// - rx irq on enable and threshold flag
// - break irq on enables and break/overrun
// - fault irq on enables and fault summary
// - fault enable alone gives fault, break irqs
// - four irq lines, driven independently
// - tx low flag re-sets if still low; code re-sets at or below threshold
// - rx threshold flag, re-sets while met
// - fifo counts: tx high, rx low byte
// - break sets framing, blocks fifo writes
// - tx pin from port bits until enabled
// - tx off resets transmitter, pin level
// - change on falling, sample on rising
// - eight data bits, no parity
`timescale 1ns/1ps
`include "sync_serial_defines.vh"

module sync_serial_port (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rxd,
    input  wire        sck_in,
    output reg         sck_out,
    output reg         sck_oe,
    output reg         txd_out,
    output reg         txd_oe,
    output reg         rx_fault_irq,
    output reg         rx_data_irq,
    output reg         break_irq,
    output reg         tx_empty_irq
);

// ----------------------------------------------------------------------
// registers and storage
// ----------------------------------------------------------------------
reg  [7:0]  ctrl_q, flags_q, div_q, zero_run_q;
reg  [1:0]  pin_q;
reg  [3:0]  tx_threshold_field_q, rx_threshold_field_q;
reg  [7:0]  tx_mem [0:15];
reg  [7:0]  rx_mem [0:15];
reg  [3:0]  tx_rd_q, tx_wr_q, rx_rd_q, rx_wr_q;
reg  [4:0]  tx_cnt_q, rx_cnt_q;
reg  [7:0]  tx_shifter_q, rx_shifter_q;
reg  [3:0]  tx_bit_q, rx_bit_q;
reg         overrun_flag_q, tx_busy_q, sck_int_q, sck_prev_q, brk_q;
reg  [1:0]  sck_sync_q, rxd_sync_q;

wire acc      = psel & penable & pready;
wire wr_acc   = acc & pwrite;
wire rd_acc   = acc & ~pwrite;
wire tx_on    = ctrl_q[`CTRL_TX_ON];
wire rx_on    = ctrl_q[`CTRL_RX_ON];
wire clk_ext  = ctrl_q[`CTRL_CLK_EXT];
wire tx_push  = wr_acc && paddr == `OFS_TX_FIFO_PORT &&
                tx_cnt_q != `FIFO_DEPTH;
wire rx_pop   = rd_acc && paddr == `OFS_RX_FIFO_PORT && rx_cnt_q != 5'h00;
wire flag_wr  = wr_acc && paddr == `OFS_SERIAL_FLAGS;
wire ls_wr    = wr_acc && paddr == `OFS_LINE_STATUS;

// ----------------------------------------------------------------------
// serial clock: internal divider or synchronised external pin
// ----------------------------------------------------------------------
// edges of the serial clock
wire sck_now  = clk_ext ? sck_sync_q[1] : sck_int_q;
wire sck_fall = sck_prev_q & ~sck_now;
wire sck_rise = ~sck_prev_q & sck_now;
wire run_int  = tx_busy_q & ~clk_ext;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sck_sync_q <= 2'b11;
        rxd_sync_q <= 2'b11;
        sck_prev_q <= 1'b1;
        div_q      <= 8'h00;
        sck_int_q  <= 1'b1;
    end else begin
        sck_sync_q <= {sck_sync_q[0], sck_in};
        rxd_sync_q <= {rxd_sync_q[0], rxd};
        sck_prev_q <= sck_now;
        // pulses only while a character is shifting
        if (run_int) begin
            if (div_q == `SCK_HALF_DIV - 8'h01) begin
                div_q     <= 8'h00;
                sck_int_q <= ~sck_int_q;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end else begin
            div_q     <= 8'h00;
            sck_int_q <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------------
// fifo checked as bit 7 goes out
wire last_bit = tx_busy_q && sck_fall && tx_bit_q == `BITS_PER_CHAR - 4'h2;
// last character ends on the edge taking bit 7
wire tx_end   = tx_busy_q && sck_rise && tx_bit_q == `BITS_PER_CHAR - 4'h1;
// idle start takes the first byte at once, without waiting for an edge
wire tx_start = tx_on && !tx_busy_q && tx_cnt_q != 5'h00;
wire tx_pop_shift = tx_start || (last_bit && tx_cnt_q != 5'h00);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_shifter_q <= 8'h00;
        tx_bit_q     <= 4'h0;
        tx_busy_q    <= 1'b0;
        txd_out      <= 1'b1;
        txd_oe       <= 1'b0;
        sck_out      <= 1'b1;
        sck_oe       <= 1'b0;
    end else begin
        sck_out <= sck_int_q;
        sck_oe  <= ~clk_ext;
        if (!tx_on) begin
            // transmitter reset at once, pin from port bits
            tx_busy_q <= 1'b0;
            tx_bit_q  <= 4'h0;
            txd_out   <= pin_q[`PIN_LEVEL];
            txd_oe    <= pin_q[`PIN_DIR];
        end else begin
            txd_oe <= 1'b1;
            if (tx_start) begin
                // bit 0 goes out on the first falling edge
                tx_shifter_q <= tx_mem[tx_rd_q];
                tx_bit_q     <= 4'hf;
                tx_busy_q    <= 1'b1;
            end else if (last_bit) begin
                txd_out <= tx_shifter_q[7];
                if (tx_cnt_q != 5'h00) begin
                    tx_shifter_q <= tx_mem[tx_rd_q];
                    tx_bit_q     <= 4'hf;
                end else begin
                    tx_bit_q <= `BITS_PER_CHAR - 4'h1;
                end
            end else if (tx_end) begin
                tx_busy_q <= 1'b0;
            end else if (tx_busy_q && sck_fall) begin
                tx_bit_q <= tx_bit_q + 4'h1;
                txd_out  <= tx_shifter_q[tx_bit_q[2:0] + 3'h1];
            end
        end
    end
end

// ----------------------------------------------------------------------
// receiver
// ----------------------------------------------------------------------
wire rx_full  = rx_cnt_q == `FIFO_DEPTH;
wire rx_done  = rx_on && !overrun_flag_q && sck_rise &&
                rx_bit_q == `BITS_PER_CHAR - 4'h1;
// no fifo writes during a break, its last zero included
wire rx_push  = rx_done && !rx_full && !brk_q &&
                !(zero_run_q == 8'h0f && !rxd_sync_q[1]);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_shifter_q <= 8'h00;
        rx_bit_q     <= 4'h0;
        zero_run_q   <= 8'h00;
        brk_q        <= 1'b0;
    end else begin
        if (!rx_on) begin
            rx_bit_q <= 4'h0;
        end else if (!overrun_flag_q && sck_rise) begin
            rx_shifter_q <= {rxd_sync_q[1], rx_shifter_q[7:1]};
            rx_bit_q     <= (rx_bit_q == `BITS_PER_CHAR - 4'h1) ?
                            4'h0 : rx_bit_q + 4'h1;
        end
        // break: two whole characters of zeros
        if (rx_on && sck_rise) begin
            if (rxd_sync_q[1])
                zero_run_q <= 8'h00;
            else if (zero_run_q != 8'hff)
                zero_run_q <= zero_run_q + 8'h01;
        end
        brk_q <= zero_run_q >= 8'h10;
    end
end

// ----------------------------------------------------------------------
// fifos and counts
// ----------------------------------------------------------------------
wire [7:0] rx_byte = {rxd_sync_q[1], rx_shifter_q[7:1]};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_rd_q  <= 4'h0;
        tx_wr_q  <= 4'h0;
        rx_rd_q  <= 4'h0;
        rx_wr_q  <= 4'h0;
        tx_cnt_q <= 5'h00;
        rx_cnt_q <= 5'h00;
    end else begin
        if (tx_push) begin
            tx_mem[tx_wr_q] <= pwdata[7:0];
            tx_wr_q         <= tx_wr_q + 4'h1;
        end
        if (tx_pop_shift)
            tx_rd_q <= tx_rd_q + 4'h1;
        tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop_shift};
        if (rx_push) begin
            rx_mem[rx_wr_q] <= rx_byte;
            rx_wr_q         <= rx_wr_q + 4'h1;
        end
        if (rx_pop)
            rx_rd_q <= rx_rd_q + 4'h1;
        rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
    end
end

// ----------------------------------------------------------------------
// flags: hardware set wins over software clear
// ----------------------------------------------------------------------
// below threshold
wire tx_low   = tx_cnt_q < {1'b0, tx_threshold_field_q};
// at or below threshold re-sets after clear
wire tx_relow = tx_cnt_q <= {1'b0, tx_threshold_field_q};
wire rx_met   = rx_cnt_q >= {1'b0, rx_threshold_field_q};
wire [7:0] wclr = flag_wr ? pwdata[7:0] : 8'hff;
wire       tx_clr = ~wclr[`FLG_TX_LOW];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        flags_q        <= `FLAGS_RESET;
        overrun_flag_q <= 1'b0;
    end else begin
        // writing 0 clears, writing 1 keeps
        flags_q[`FLG_TX_LOW] <= tx_low | (tx_clr & tx_relow) |
                                (flags_q[`FLG_TX_LOW] & ~tx_clr);
        flags_q[`FLG_TX_DONE] <= (last_bit && tx_cnt_q == 5'h00) |
                                 (flags_q[`FLG_TX_DONE] &
                                  wclr[`FLG_TX_DONE] & ~tx_push);
        flags_q[`FLG_RX_THRESH] <= rx_met |
                                   (flags_q[`FLG_RX_THRESH] &
                                    wclr[`FLG_RX_THRESH]);
        flags_q[`FLG_FRAMING] <= brk_q |
                                 (flags_q[`FLG_FRAMING] & wclr[`FLG_FRAMING]);
        flags_q[`FLG_LINE_BREAK] <= brk_q |
                                    (flags_q[`FLG_LINE_BREAK] &
                                     wclr[`FLG_LINE_BREAK]);
        flags_q[`FLG_PARITY] <= flags_q[`FLG_PARITY] & wclr[`FLG_PARITY];
        flags_q[`FLG_DATA_WAIT] <= 1'b0;
        flags_q[`FLG_FAULT_SUM] <= brk_q |
                                   (flags_q[`FLG_FAULT_SUM] &
                                    wclr[`FLG_FAULT_SUM]);
        // overrun when the fifo has no room
        overrun_flag_q <= (rx_done && rx_full) |
                          (overrun_flag_q & ~(ls_wr & ~pwdata[0]));
    end
end

// ----------------------------------------------------------------------
// interrupt request lines
// ----------------------------------------------------------------------
wire rx_irq_enable  = ctrl_q[`CTRL_RX_IRQ_EN];
wire rx_fault_irq_enable = ctrl_q[`CTRL_FAULT_IRQ_EN];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_fault_irq <= 1'b0;
        rx_data_irq  <= 1'b0;
        break_irq    <= 1'b0;
        tx_empty_irq <= 1'b0;
    end else begin
        rx_fault_irq <= (rx_irq_enable | rx_fault_irq_enable) & flags_q[`FLG_FAULT_SUM];
        // data-ready never counts in this mode
        rx_data_irq  <= rx_irq_enable & flags_q[`FLG_RX_THRESH];
        break_irq    <= (rx_irq_enable | rx_fault_irq_enable) &
                        (flags_q[`FLG_LINE_BREAK] | overrun_flag_q);
        tx_empty_irq <= ctrl_q[`CTRL_TX_IRQ_EN] & flags_q[`FLG_TX_LOW];
    end
end

// ----------------------------------------------------------------------
// apb slave: one wait-free access, unmapped reads zero with error
// ----------------------------------------------------------------------
reg [31:0] rd_d;
reg        hit_d;

always @* begin
    rd_d  = 32'h00000000;
    hit_d = 1'b1;
    case (paddr)
        `OFS_SERIAL_CTRL:  rd_d = {24'h000000, ctrl_q};
        `OFS_TX_FIFO_PORT: rd_d = 32'h00000000;
        `OFS_RX_FIFO_PORT: rd_d = {24'h000000, rx_mem[rx_rd_q]};
        `OFS_SERIAL_FLAGS: rd_d = {24'h000000, flags_q};
        `OFS_FIFO_CTRL:    rd_d = {24'h000000, tx_threshold_field_q,
                                   rx_threshold_field_q};
        // tx count high byte, rx low byte
        `OFS_FIFO_COUNT:   rd_d = {16'h0000, 3'h0, tx_cnt_q,
                                   3'h0, rx_cnt_q};
        `OFS_PORT_PIN:     rd_d = {30'h0, pin_q};
        `OFS_LINE_STATUS:  rd_d = {31'h0, overrun_flag_q};
        default:           hit_d = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata               <= 32'h00000000;
        pready               <= 1'b0;
        pslverr              <= 1'b0;
        ctrl_q               <= 8'h00;
        pin_q                <= 2'b00;
        tx_threshold_field_q <= 4'h8;
        rx_threshold_field_q <= 4'h1;
    end else begin
        pready  <= psel & ~penable;
        pslverr <= psel & ~penable & ~hit_d;
        prdata  <= (psel & ~penable & ~pwrite) ? rd_d : 32'h00000000;
        if (wr_acc && pready) begin
            case (paddr)
                `OFS_SERIAL_CTRL: ctrl_q <= pwdata[7:0];
                `OFS_PORT_PIN:    pin_q  <= pwdata[1:0];
                `OFS_FIFO_CTRL: begin
                    tx_threshold_field_q <= pwdata[7:4];
                    rx_threshold_field_q <= pwdata[3:0];
                end
                default: ;
            endcase
        end
    end
end

endmodule // sync_serial_port

// ===== sim/sync_serial_port_assertions.sv
/* checker for the serial port's bus and clock pins.
   assumes it is bound onto sync_serial_port, pclk domain only. */
`timescale 1ns/1ps
module sync_serial_port_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sck_out,
    input wire logic        sck_oe,
    input wire logic        txd_out,
    input wire logic        rx_fault_irq,
    input wire logic        rx_data_irq,
    input wire logic        break_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // properties
    // ----
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held past one cycle");
    property p_ready_setup; psel && !penable |=> pready; endproperty
    a_ready_setup: assert property (p_ready_setup)
        else $error("no answer one cycle after setup");
    property p_ready_access; pready |-> psel && penable; endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("pready outside access phase");
    property p_err_unmapped;
        psel && !penable && paddr > 12'h01c |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped address not refused");
    property p_ok_mapped;
        psel && !penable && paddr <= 12'h01c && paddr[1:0] == 2'b00
            |=> !pslverr;
    endproperty
    a_ok_mapped: assert property (p_ok_mapped)
        else $error("mapped address refused");
    property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused read returned data");
    // low phase never longer than half a bit
    property p_sck_low; sck_oe && $fell(sck_out) |-> ##[1:4] sck_out;
    endproperty
    a_sck_low: assert property (p_sck_low)
        else $error("serial clock low too long");
    property p_txd_rise;
        sck_oe && $rose(sck_out) |-> $stable(txd_out);
    endproperty
    a_txd_rise: assert property (p_txd_rise)
        else $error("tx data moved on rising clock");
    c_sck: cover property (sck_oe && $fell(sck_out));
    c_rx: cover property (rx_data_irq);
    c_brk: cover property (break_irq && rx_fault_irq);
    c_err: cover property (pslverr);
endmodule // sync_serial_port_checker

// ===== sim/serial_partner.sv
/* serial partner: captures tx bytes on the internal clock and sends
   rx bytes on its own 160 ns clock. assumes tx pin has a pull-up. */
`timescale 1ns/1ps
module serial_partner (
    input  wire logic sck_out,
    input  wire logic sck_oe,
    input  wire logic txd_out,
    input  wire logic txd_oe,
    output logic      rxd,
    output logic      sck_in
);
    logic       sck_line;
    logic       txd_line;
    logic [7:0] shf;
    int         n_bit;
    int         n_rise;
    logic [7:0] got [$];
    assign sck_line = sck_oe ? sck_out : sck_in;
    assign txd_line = txd_oe ? txd_out : 1'b1;
    initial begin
        rxd = 1'b1;
        sck_in = 1'b1;
        n_bit = 0;
        n_rise = 0;
    end
    always @(posedge sck_line) begin
        if (sck_oe) begin
            shf = {txd_line, shf[7:1]};
            n_rise++;
            n_bit++;
            if (n_bit == 8) begin
                got.push_back(shf);
                n_bit = 0;
            end
        end
    end
    task automatic send(input logic [7:0] b);
        #7;
        for (int i = 0; i < 8; i++) begin
            #80 sck_in = 1'b0;
            rxd = b[i];
            #80 sck_in = 1'b1;
        end
        // hold time over: line no longer shows the bit
        #80 rxd = ~b[7];
    endtask
endmodule // serial_partner

// ===== sim/tb.sv
/* testbench of the synchronous serial port.
   assumes the defines header and the partner model beside it. */
`timescale 1ns/1ps
`include "sync_serial_defines.vh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, rxd, sck_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, r;
    logic        pready, pslverr, sck_out, sck_oe, txd_out, txd_oe, e;
    logic        rx_fault_irq, rx_data_irq, break_irq, tx_empty_irq;
    logic [7:0]  b [0:3];
    int          errors, n_compared, k;

    sync_serial_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe(sck_oe), .txd_out(txd_out), .txd_oe(txd_oe),
        .rx_fault_irq(rx_fault_irq), .rx_data_irq(rx_data_irq),
        .break_irq(break_irq), .tx_empty_irq(tx_empty_irq));
    serial_partner i_partner (.sck_out(sck_out), .sck_oe(sck_oe),
        .txd_out(txd_out), .txd_oe(txd_oe), .rxd(rxd), .sck_in(sck_in));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] cnt(input logic [4:0] t, input logic [4:0] x);
        return {19'h0, t, 3'h0, x};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        chk(n < 20, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_sck(input logic v);
        k = 0;
        while (sck_out !== v && k < 400) begin
            @(posedge pclk);
            k++;
        end
    endtask
    initial begin
        #300us;
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        errors = 0;
        n_compared = 0;
        seed = 32'd92169;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OFS_SERIAL_FLAGS, 0); chk(r, 32'h60);
        apb(0, `OFS_FIFO_COUNT, 0); chk(r, cnt(0, 0));
        apb(0, 12'h020, 0); chk(e, 1'b1);
        chk(r, 32'h0);
        chk({sck_out, rx_fault_irq, rx_data_irq, break_irq, tx_empty_irq}, 5'h10);
        $display("reset test done");
        // pin follows port bits before enable
        apb(1, `OFS_PORT_PIN, 32'h2);
        repeat (2) @(posedge pclk);
        chk({txd_oe, txd_out}, 2'b10);
        apb(1, `OFS_PORT_PIN, 32'h3);
        repeat (2) @(posedge pclk);
        chk({txd_oe, txd_out}, 2'b11);
        $display("port pin test done");
        apb(1, `OFS_SERIAL_CTRL, 32'ha0);
        repeat (2) @(posedge pclk);
        chk(tx_empty_irq, 1);
        // clear low flag while fifo holds too few
        apb(1, `OFS_SERIAL_FLAGS, 32'h0);
        apb(0, `OFS_SERIAL_FLAGS, 0); chk(r, 32'h20);
        // msb low, so the held line differs from idle
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            b[i] = seed[7:0] & 8'h7f;
            apb(1, `OFS_TX_FIFO_PORT, {24'h0, b[i]});
        end
        k = 0;
        while (i_partner.got.size() < 3 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        repeat (8) @(posedge pclk);
        chk(i_partner.got.size(), 3);
        for (int i = 0; i < 3; i++) chk(i_partner.got[i], b[i]);
        chk(i_partner.n_rise, 24);
        chk({sck_out, txd_out}, {1'b1, b[2][7]});
        apb(0, `OFS_SERIAL_FLAGS, 0); chk(r, 32'h60);
        $display("transmit test done");
        apb(1, `OFS_PORT_PIN, 32'h2);
        apb(1, `OFS_TX_FIFO_PORT, 32'h55);
        wait_sck(1'b0);
        wait_sck(1'b1);
        apb(1, `OFS_SERIAL_CTRL, 32'h0);
        repeat (8) @(posedge pclk);
        chk({txd_oe, txd_out, sck_out}, 3'b101);
        apb(0, `OFS_FIFO_COUNT, 0); chk(r, cnt(0, 0));
        $display("abort test done");
        apb(1, `OFS_SERIAL_CTRL, 32'h52);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            b[i] = seed[7:0] | 8'h80;
            i_partner.send(b[i]);
        end
        repeat (8) @(posedge pclk);
        chk(rx_data_irq, 1);
        apb(0, `OFS_FIFO_COUNT, 0); chk(r, cnt(0, 4));
        for (int i = 0; i < 4; i++) begin
            apb(0, `OFS_RX_FIFO_PORT, 0); chk(r, {24'h0, b[i]});
        end
        apb(0, `OFS_SERIAL_FLAGS, 0); chk(r[1], 1);
        apb(1, `OFS_SERIAL_FLAGS, 32'h0);
        repeat (2) @(posedge pclk);
        chk(rx_data_irq, 0);
        $display("receive test done");
        apb(1, `OFS_SERIAL_CTRL, 32'h1a);
        i_partner.send(8'h00);
        i_partner.send(8'h00);
        repeat (8) @(posedge pclk);
        chk({rx_fault_irq, break_irq, rx_data_irq}, 3'b110);
        apb(0, `OFS_SERIAL_FLAGS, 0); chk({r[7], r[4:3]}, 3'b111);
        apb(0, `OFS_FIFO_COUNT, 0); chk(r, cnt(0, 1));
        $display("break test done");
        // fill the fifo, one byte more overruns
        for (int i = 0; i < 16; i++) i_partner.send(8'hff);
        repeat (8) @(posedge pclk);
        apb(0, `OFS_LINE_STATUS, 0); chk(r, 32'h1);
        apb(0, `OFS_FIFO_COUNT, 0); chk(r, cnt(0, 16));
        $display("overrun test done");
        wrap_up();
    end
endmodule // tb

bind sync_serial_port sync_serial_port_checker i_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_out(sck_out), .sck_oe(sck_oe), .txd_out(txd_out),
    .rx_fault_irq(rx_fault_irq), .rx_data_irq(rx_data_irq),
    .break_irq(break_irq));
